// ---- verilog/qmfc_pkg.sv ----
package qmfc_pkg;
  localparam int NUM_CH = 4;
  localparam int PRI_W = 8;
  localparam int VEC_W = 32;
  localparam int PD_W = 30;
  localparam int PD_VEC_W = 120;
  localparam int QUANTA_W = 16;
  localparam int CORR_W = 64;
  localparam int NUM_PATH = 2;
  localparam int PATH_EXPRESS = 0;
  localparam int PATH_PREEMPT = 1;
  localparam logic [VEC_W-1:0] LINK_PAUSE_MASK = 32'h0101_0101;

  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_XOFF_E = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_XOFF_P = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFS_PD_STROBE = 12'h00C;
  localparam logic [APB_ADDR_W-1:0] OFS_STAT_E = 12'h010;
  localparam logic [APB_ADDR_W-1:0] OFS_STAT_P = 12'h014;
  localparam logic [APB_ADDR_W-1:0] OFS_TICKS = 12'h018;
  localparam logic [APB_ADDR_W-1:0] OFS_PD_BASE = 12'h020;
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_LPI_LSB = 4;
  localparam int CTRL_STOP_LSB = 8;
  localparam int CTRL_AUTO_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] XOFF_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    grp_high_rate = 2'b00,
    grp_quad_zero = 2'b01,
    grp_quad_one = 2'b10
  } qmfc_group_t;

  typedef enum logic [1:0] {
    tx_idle = 2'b01,
    tx_send = 2'b10
  } qmfc_tx_state_t;
endpackage

// ---- verilog/qmfc_if.sv ----
`timescale 1ns/10ps
// Instance name of this interface is the signal prefix; GROUP names the MAC group
interface qmfc_if
  import qmfc_pkg::*;
#(
  parameter qmfc_group_t GROUP = grp_quad_zero
) (
  input wire logic pclk,
  input wire logic presetn
);
  logic [NUM_CH-1:0] tx_hold_req;
  logic [NUM_CH-1:0] lpi_txhold;
  logic [NUM_CH-1:0] millisecond_toggle_timebase;
  logic [NUM_CH-1:0] mac_stop_tx;
  logic [VEC_W-1:0] emac_xoff_gen;
  logic [VEC_W-1:0] pmac_xoff_gen;
  logic [PD_VEC_W-1:0] mac_peer_delay;
  logic [NUM_CH-1:0] mac_peer_delay_val;
  logic [VEC_W-1:0] emac_pause_on;
  logic [VEC_W-1:0] pmac_pause_on;

  modport mac (
    input pclk, presetn, tx_hold_req, lpi_txhold, millisecond_toggle_timebase, mac_stop_tx,
    input emac_xoff_gen, pmac_xoff_gen, mac_peer_delay, mac_peer_delay_val,
    output emac_pause_on, pmac_pause_on
  );
  modport app (
    input pclk, presetn, emac_pause_on, pmac_pause_on,
    output tx_hold_req, lpi_txhold, millisecond_toggle_timebase, mac_stop_tx,
    output emac_xoff_gen, pmac_xoff_gen, mac_peer_delay, mac_peer_delay_val
  );
endinterface

// ---- verilog/qmfc_sync_edge.sv ----
`timescale 1ns/10ps
module qmfc_sync_edge #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] change
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;
  logic [W-1:0] next_last;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
    next_last = sync;
  end

  // Only sync and last feed logic; meta stays private to the pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign level = sync;
  assign change = sync ^ last;
endmodule

// ---- verilog/qmfc_mac_end.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Names: prefix, group, function, underscore joined
// - Interface instance name prefixes every signal
// - Group selects high-rate, quad zero, quad one
// - Hold request holds and preempts preemptable path
// - Low-power hold blocks new frame starts
// - Application toggles time base every millisecond
// - Stop takes effect after current frame ends
// - No new frame while stop stays high
// - Application drives 32-bit generate vector per path
// - PFC mode: one generate bit per class
// - Link pause mode: only bit 0 of each channel used
// - Peer delay added to one-step correction field
// - Application pulses delay strobe for one cycle
// - Delay data ignored once strobe is low
// - Pause indication: 32 bits per path
// - Bit 0 per channel also flags link pause
// - Indication high while pause counter runs
// - Received XOFF frame starts the pause counter
// - Link pause stops transmitter unless compensation set
// - With compensation set, application asserts stop
module qmfc_mac_end
  import qmfc_pkg::*;
(
  qmfc_if.mac link,
  input wire logic pfc_mode,
  input wire logic pause_compensation_bit,
  input wire logic [NUM_CH-1:0] emac_pending,
  input wire logic [NUM_CH-1:0] pmac_pending,
  input wire logic [NUM_CH-1:0] frame_done,
  input wire logic [NUM_PATH-1:0][NUM_CH-1:0] rx_pause_valid,
  input wire logic [NUM_PATH-1:0][VEC_W-1:0] rx_pause_class,
  input wire logic [NUM_PATH-1:0][NUM_CH-1:0][QUANTA_W-1:0] rx_pause_quanta,
  input wire logic [NUM_CH-1:0] ts_update_valid,
  input wire logic [NUM_CH-1:0][CORR_W-1:0] ts_corr_in,
  output logic [NUM_CH-1:0] tx_start_emac,
  output logic [NUM_CH-1:0] tx_start_pmac,
  output logic [NUM_CH-1:0] tx_busy,
  output logic [NUM_CH-1:0] pmac_preempt,
  output logic [NUM_CH-1:0] ms_tick,
  output logic [NUM_PATH-1:0][VEC_W-1:0] xoff_req,
  output logic [NUM_CH-1:0][PD_W-1:0] peer_delay,
  output logic [NUM_CH-1:0] ts_corr_valid,
  output logic [NUM_CH-1:0][CORR_W-1:0] ts_corr_out
);
  logic clk;
  logic rst_n;
  logic [NUM_CH-1:0] lpi_s;
  logic [NUM_CH-1:0] tgl_change;
  logic [VEC_W-1:0] xoff_e_s;
  logic [VEC_W-1:0] xoff_p_s;
  logic [NUM_PATH-1:0][VEC_W-1:0] pause_run;
  logic [NUM_CH-1:0] next_ms_tick;
  logic [NUM_PATH-1:0][VEC_W-1:0] next_xoff_req;

  assign clk = link.pclk;
  assign rst_n = link.presetn;

  // Asynchronous inputs pass two flops first
  qmfc_sync_edge #(.W(NUM_CH)) u_sync_lpi (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(link.lpi_txhold),
    .level(lpi_s),
    .change()
  );
  qmfc_sync_edge #(.W(NUM_CH)) u_sync_tgl (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(link.millisecond_toggle_timebase),
    .level(),
    .change(tgl_change)
  );
  qmfc_sync_edge #(.W(VEC_W)) u_sync_xe (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(link.emac_xoff_gen),
    .level(xoff_e_s),
    .change()
  );
  qmfc_sync_edge #(.W(VEC_W)) u_sync_xp (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(link.pmac_xoff_gen),
    .level(xoff_p_s),
    .change()
  );

  always_comb begin
    next_ms_tick = tgl_change;
    if (pfc_mode) begin
      next_xoff_req[PATH_EXPRESS] = xoff_e_s;
      next_xoff_req[PATH_PREEMPT] = xoff_p_s;
    end else begin
      next_xoff_req[PATH_EXPRESS] = xoff_e_s & LINK_PAUSE_MASK;
      next_xoff_req[PATH_PREEMPT] = xoff_p_s & LINK_PAUSE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_tick <= '0;
      xoff_req <= '0;
    end else begin
      ms_tick <= next_ms_tick;
      xoff_req <= next_xoff_req;
    end
  end

  // Pause counters, one per path, channel and class; unit is one clock per quantum
  genvar p, c, k;
  generate
    for (p = 0; p < NUM_PATH; p++) begin : g_path
      for (c = 0; c < NUM_CH; c++) begin : g_ch
        for (k = 0; k < PRI_W; k++) begin : g_cls
          logic [QUANTA_W-1:0] cnt;
          logic [QUANTA_W-1:0] next_cnt;
          logic hit;
          logic next_run;
          always_comb begin
            hit = rx_pause_valid[p][c] && (pfc_mode ? rx_pause_class[p][c*PRI_W+k] : (k == 0));
            if (hit) begin
              next_cnt = rx_pause_quanta[p][c];
            end else if (cnt != '0) begin
              next_cnt = cnt - 1'b1;
            end else begin
              next_cnt = '0;
            end
            next_run = (next_cnt != '0);
          end
          always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
              cnt <= '0;
              pause_run[p][c*PRI_W+k] <= 1'b0;
            end else begin
              cnt <= next_cnt;
              pause_run[p][c*PRI_W+k] <= next_run;
            end
          end
        end
      end
    end
  endgenerate

  assign link.emac_pause_on = pause_run[PATH_EXPRESS];
  assign link.pmac_pause_on = pause_run[PATH_PREEMPT];

  // Per channel transmit control, peer delay and correction update
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_tx
      qmfc_tx_state_t state;
      qmfc_tx_state_t next_state;
      logic on_pmac;
      logic next_on_pmac;
      logic next_start_e;
      logic next_start_p;
      logic may_start;
      logic block_e;
      logic block_p;
      logic [PD_W-1:0] next_pd;
      logic [CORR_W-1:0] next_corr;
      always_comb begin
        // Gate only at frame boundaries so a running frame is never cut
        may_start = !lpi_s[c] && !link.mac_stop_tx[c];
        block_e = !pfc_mode && !pause_compensation_bit && pause_run[PATH_EXPRESS][c*PRI_W];
        block_p = !pfc_mode && !pause_compensation_bit && pause_run[PATH_PREEMPT][c*PRI_W];
        next_state = state;
        next_on_pmac = on_pmac;
        next_start_e = 1'b0;
        next_start_p = 1'b0;
        case (state)
          tx_idle: begin
            if (may_start && emac_pending[c] && !block_e) begin
              next_state = tx_send;
              next_on_pmac = 1'b0;
              next_start_e = 1'b1;
            end else if (may_start && pmac_pending[c] && !link.tx_hold_req[c] && !block_p) begin
              next_state = tx_send;
              next_on_pmac = 1'b1;
              next_start_p = 1'b1;
            end
          end
          tx_send: begin
            if (frame_done[c]) begin
              next_state = tx_idle;
            end
          end
          default: begin
            next_state = tx_idle;
          end
        endcase
        next_pd = link.mac_peer_delay_val[c] ? link.mac_peer_delay[c*PD_W +: PD_W] : peer_delay[c];
        next_corr = ts_corr_in[c] + {{(CORR_W-PD_W){1'b0}}, peer_delay[c]};
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          state <= tx_idle;
          on_pmac <= 1'b0;
          tx_start_emac[c] <= 1'b0;
          tx_start_pmac[c] <= 1'b0;
          tx_busy[c] <= 1'b0;
          pmac_preempt[c] <= 1'b0;
          peer_delay[c] <= '0;
          ts_corr_valid[c] <= 1'b0;
          ts_corr_out[c] <= '0;
        end else begin
          state <= next_state;
          on_pmac <= next_on_pmac;
          tx_start_emac[c] <= next_start_e;
          tx_start_pmac[c] <= next_start_p;
          tx_busy[c] <= (next_state == tx_send);
          pmac_preempt[c] <= (next_state == tx_send) && next_on_pmac && link.tx_hold_req[c];
          peer_delay[c] <= next_pd;
          ts_corr_valid[c] <= ts_update_valid[c];
          if (ts_update_valid[c]) begin
            ts_corr_out[c] <= next_corr;
          end
        end
      end
    end
  endgenerate
endmodule

// ---- verilog/qmfc_app_end.sv ----
`timescale 1ns/10ps
module qmfc_app_end
  import qmfc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  qmfc_if.app link
);
  logic [31:0] ctrl;
  logic [VEC_W-1:0] xoff_e;
  logic [VEC_W-1:0] xoff_p;
  logic [NUM_CH-1:0][PD_W-1:0] pd;
  logic [NUM_CH-1:0] pd_val;
  logic [NUM_CH-1:0] stop;
  logic [NUM_CH-1:0] tgl;
  logic [31:0] tick_cnt;
  logic [31:0] ms_count;
  logic [31:0] next_ctrl;
  logic [VEC_W-1:0] next_xoff_e;
  logic [VEC_W-1:0] next_xoff_p;
  logic [NUM_CH-1:0][PD_W-1:0] next_pd;
  logic [NUM_CH-1:0] next_pd_val;
  logic [NUM_CH-1:0] next_stop;
  logic [NUM_CH-1:0] next_tgl;
  logic [31:0] next_tick_cnt;
  logic [31:0] next_ms_count;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic commit;
  logic is_pd;
  logic [1:0] pd_idx;
  logic mapped;
  logic [NUM_CH-1:0] link_paused;
  logic tick_wrap;
  logic [31:0] rd;

  always_comb begin
    commit = psel && penable && pready && pwrite;
    is_pd = (paddr[APB_ADDR_W-1:4] == OFS_PD_BASE[APB_ADDR_W-1:4]) && (paddr[1:0] == 2'b00);
    pd_idx = paddr[3:2];
    mapped = 1'b1;
    rd = 32'h0000_0000;
    if (is_pd) begin
      rd = {{(32-PD_W){1'b0}}, pd[pd_idx]};
    end else begin
      case (paddr)
        OFS_CTRL: rd = ctrl;
        OFS_XOFF_E: rd = xoff_e;
        OFS_XOFF_P: rd = xoff_p;
        OFS_PD_STROBE: rd = 32'h0000_0000;
        OFS_STAT_E: rd = link.emac_pause_on;
        OFS_STAT_P: rd = link.pmac_pause_on;
        OFS_TICKS: rd = ms_count;
        default: mapped = 1'b0;
      endcase
    end
    // One wait state so every bus output comes from a flop
    next_pready = psel && penable && !pready;
    next_prdata = next_pready ? rd : prdata;
    next_pslverr = next_pready && !mapped;
    next_ctrl = ctrl;
    next_xoff_e = xoff_e;
    next_xoff_p = xoff_p;
    next_pd = pd;
    next_pd_val = '0;
    if (commit && mapped) begin
      if (is_pd) begin
        next_pd[pd_idx] = pwdata[PD_W-1:0];
      end else begin
        case (paddr)
          OFS_CTRL: next_ctrl = pwdata;
          OFS_XOFF_E: next_xoff_e = pwdata;
          OFS_XOFF_P: next_xoff_p = pwdata;
          OFS_PD_STROBE: next_pd_val = pwdata[NUM_CH-1:0];
          default: next_ctrl = ctrl;
        endcase
      end
    end
    // Compensation mode leaves the MAC running, so link pause must stop it from here
    for (int i = 0; i < NUM_CH; i++) begin
      link_paused[i] = link.emac_pause_on[i*PRI_W] || link.pmac_pause_on[i*PRI_W];
    end
    next_stop = next_ctrl[CTRL_STOP_LSB +: NUM_CH] | (next_ctrl[CTRL_AUTO_BIT] ? link_paused : '0);
    tick_wrap = (tick_cnt == 32'(TICK_CYCLES_P - 1));
    next_tick_cnt = tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    next_tgl = tick_wrap ? ~tgl : tgl;
    next_ms_count = tick_wrap ? ms_count + 32'h0000_0001 : ms_count;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      xoff_e <= XOFF_RESET;
      xoff_p <= XOFF_RESET;
      pd <= '0;
      pd_val <= '0;
      stop <= '0;
      tgl <= '0;
      tick_cnt <= 32'h0000_0000;
      ms_count <= 32'h0000_0000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      xoff_e <= next_xoff_e;
      xoff_p <= next_xoff_p;
      pd <= next_pd;
      pd_val <= next_pd_val;
      stop <= next_stop;
      tgl <= next_tgl;
      tick_cnt <= next_tick_cnt;
      ms_count <= next_ms_count;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign link.tx_hold_req = ctrl[CTRL_HOLD_LSB +: NUM_CH];
  assign link.lpi_txhold = ctrl[CTRL_LPI_LSB +: NUM_CH];
  assign link.mac_stop_tx = stop;
  assign link.millisecond_toggle_timebase = tgl;
  assign link.emac_xoff_gen = xoff_e;
  assign link.pmac_xoff_gen = xoff_p;
  assign link.mac_peer_delay = {pd[3], pd[2], pd[1], pd[0]};
  assign link.mac_peer_delay_val = pd_val;
endmodule

// ---- dv/qmfc_sva.sv ----
`timescale 1ns/10ps
module qmfc_sva
  import qmfc_pkg::*;
#(
  parameter int TICK = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_CH-1:0] tx_hold_req,
  input wire logic [NUM_CH-1:0] lpi_txhold,
  input wire logic [NUM_CH-1:0] millisecond_toggle_timebase,
  input wire logic [NUM_CH-1:0] mac_stop_tx,
  input wire logic [VEC_W-1:0] emac_xoff_gen,
  input wire logic [VEC_W-1:0] pmac_xoff_gen,
  input wire logic [PD_VEC_W-1:0] mac_peer_delay,
  input wire logic [NUM_CH-1:0] mac_peer_delay_val,
  input wire logic [VEC_W-1:0] emac_pause_on,
  input wire logic [VEC_W-1:0] pmac_pause_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [NUM_CH-1:0] prev;
  logic [15:0] cnt;
  logic seen;
  logic chg;
  assign chg = millisecond_toggle_timebase != prev;

  // Period only judged after the first edge, phase at reset is free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
      cnt <= '0;
      seen <= 1'b0;
    end else begin
      prev <= millisecond_toggle_timebase;
      cnt <= chg ? 16'h0001 : cnt + 16'h0001;
      seen <= seen | chg;
    end
  end

  a_strobe_one_cycle: assert property ((mac_peer_delay_val & $past(mac_peer_delay_val)) == '0)
    else $error("peer delay strobe held longer than one cycle");
  a_toggle_in_step: assert property (millisecond_toggle_timebase == '0 || millisecond_toggle_timebase == '1)
    else $error("time base channels out of step");
  a_toggle_period: assert property (seen && chg |-> cnt == 16'(TICK))
    else $error("time base toggled at wrong spacing");
  a_toggle_no_stall: assert property (seen |-> cnt <= 16'(TICK))
    else $error("time base stopped toggling");
  a_toggle_starts: assert property (!seen |-> cnt <= 16'(TICK))
    else $error("time base never started toggling");
  a_reset_quiet: assert property (!$past(presetn) |-> mac_peer_delay_val == '0 && mac_stop_tx == '0
    && emac_pause_on == '0 && pmac_pause_on == '0)
    else $error("link outputs not idle after reset");
  cover property (|mac_peer_delay_val);
  cover property (seen && chg);
endmodule

// ---- dv/quad_mac_flow_control_sideband_test.sv ----
`timescale 1ns/10ps
module quad_mac_flow_control_sideband_test;
  import qmfc_pkg::*;
  localparam int TICK = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pfc_mode = 1'b0;
  logic comp = 1'b0;
  logic [NUM_CH-1:0] emac_pending = '0;
  logic [NUM_CH-1:0] pmac_pending = '0;
  logic [NUM_CH-1:0] frame_done = '0;
  logic [NUM_PATH-1:0][NUM_CH-1:0] rx_pause_valid = '0;
  logic [NUM_PATH-1:0][VEC_W-1:0] rx_pause_class = '0;
  logic [NUM_PATH-1:0][NUM_CH-1:0][QUANTA_W-1:0] rx_pause_quanta = '0;
  logic [NUM_CH-1:0] ts_update_valid = '0;
  logic [NUM_CH-1:0][CORR_W-1:0] ts_corr_in = '0;
  logic [NUM_CH-1:0] tx_start_emac;
  logic [NUM_CH-1:0] tx_start_pmac;
  logic [NUM_CH-1:0] tx_busy;
  logic [NUM_CH-1:0] pmac_preempt;
  logic [NUM_CH-1:0] ms_tick;
  logic [NUM_PATH-1:0][VEC_W-1:0] xoff_req;
  logic [NUM_CH-1:0][PD_W-1:0] peer_delay;
  logic [NUM_CH-1:0] ts_corr_valid;
  logic [NUM_CH-1:0][CORR_W-1:0] ts_corr_out;
  logic [33:0] apb_q[$];
  logic [7:0] tx_q[$];
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] rnd = 32'h0000_b6da;

  initial begin
    forever #5 pclk = ~pclk;
  end

  qmfc_if #(.GROUP(grp_quad_zero)) i_qmfc_if (.pclk(pclk), .presetn(presetn));
  qmfc_app_end #(.TICK_CYCLES_P(TICK)) i_qmfc_app_end (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_qmfc_if));
  qmfc_mac_end i_qmfc_mac_end (.link(i_qmfc_if), .pfc_mode(pfc_mode), .pause_compensation_bit(comp),
    .emac_pending(emac_pending), .pmac_pending(pmac_pending), .frame_done(frame_done),
    .rx_pause_valid(rx_pause_valid), .rx_pause_class(rx_pause_class), .rx_pause_quanta(rx_pause_quanta),
    .ts_update_valid(ts_update_valid), .ts_corr_in(ts_corr_in), .tx_start_emac(tx_start_emac),
    .tx_start_pmac(tx_start_pmac), .tx_busy(tx_busy), .pmac_preempt(pmac_preempt), .ms_tick(ms_tick),
    .xoff_req(xoff_req), .peer_delay(peer_delay), .ts_corr_valid(ts_corr_valid), .ts_corr_out(ts_corr_out));
  qmfc_sva #(.TICK(TICK)) i_qmfc_sva (.pclk(pclk), .presetn(presetn), .tx_hold_req(i_qmfc_if.tx_hold_req),
    .lpi_txhold(i_qmfc_if.lpi_txhold), .millisecond_toggle_timebase(i_qmfc_if.millisecond_toggle_timebase),
    .mac_stop_tx(i_qmfc_if.mac_stop_tx), .emac_xoff_gen(i_qmfc_if.emac_xoff_gen),
    .pmac_xoff_gen(i_qmfc_if.pmac_xoff_gen), .mac_peer_delay(i_qmfc_if.mac_peer_delay),
    .mac_peer_delay_val(i_qmfc_if.mac_peer_delay_val), .emac_pause_on(i_qmfc_if.emac_pause_on),
    .pmac_pause_on(i_qmfc_if.pmac_pause_on));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    $display("Checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // For reads d is the expected data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    apb_q.push_back({wr, err, d});
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pend(input int ch, input bit p, input logic v);
    @(posedge pclk);
    if (p) pmac_pending[ch] <= v;
    else emac_pending[ch] <= v;
  endtask

  task automatic wait_busy(input int ch, input logic v);
    int n;
    n = 0;
    while (tx_busy[ch] !== v && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("tx_busy", v, tx_busy[ch]);
  endtask

  task automatic end_frame(input int ch);
    @(posedge pclk);
    frame_done[ch] <= 1'b1;
    @(posedge pclk);
    frame_done[ch] <= 1'b0;
    wait_busy(ch, 1'b0);
  endtask

  // Start must stay away while the control bits hold it off
  task automatic blocked_frame(input int ch, input bit p, input logic [31:0] ctrl);
    apb(1'b1, OFS_CTRL, ctrl);
    // Low-power hold needs two sync flops before it blocks
    idle(2);
    pend(ch, p, 1'b1);
    idle(20);
    chk("tx_busy_held", 0, tx_busy[ch]);
    tx_q.push_back(8'(1 << (ch + (p ? 4 : 0))));
    apb(1'b1, OFS_CTRL, CTRL_RESET);
    wait_busy(ch, 1'b1);
    pend(ch, p, 1'b0);
    end_frame(ch);
  endtask

  task automatic xoff_rx(input int path, input int ch, input logic [15:0] q);
    @(posedge pclk);
    rx_pause_valid[path][ch] <= 1'b1;
    rx_pause_class[path] <= 32'hffff_ffff;
    rx_pause_quanta[path][ch] <= q;
    @(posedge pclk);
    rx_pause_valid[path][ch] <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      logic [33:0] e;
      e = apb_q.pop_front();
      chk("pslverr", e[32], pslverr);
      if (!e[33]) chk("prdata", e[31:0], prdata);
    end
    if (presetn && (tx_start_emac | tx_start_pmac) !== 4'h0) begin
      chk("tx_start", tx_q.size() ? tx_q.pop_front() : '0, {tx_start_pmac, tx_start_emac});
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    end_sim();
  end

  initial begin
    int ticks;
    logic [29:0] v;
    logic [63:0] c;
    logic [31:0] nr;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, CTRL_RESET);
    apb(1'b0, OFS_XOFF_E, XOFF_RESET);
    apb(1'b1, 12'hffc, 32'hffff_ffff, 1'b1);
    apb(1'b0, OFS_CTRL, CTRL_RESET);
    apb(1'b0, OFS_PD_STROBE, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      rnd = lfsr(rnd);
      nr = ~rnd;
      pfc_mode <= m[0];
      apb(1'b1, OFS_XOFF_E, rnd);
      apb(1'b1, OFS_XOFF_P, nr);
      apb(1'b0, OFS_XOFF_E, rnd);
      idle(6);
      chk("xoff_req_e", m ? rnd : rnd & LINK_PAUSE_MASK, xoff_req[PATH_EXPRESS]);
      chk("xoff_req_p", m ? nr : nr & LINK_PAUSE_MASK, xoff_req[PATH_PREEMPT]);
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rnd = lfsr(rnd);
      v = rnd[29:0];
      apb(1'b1, OFS_PD_BASE + 12'(4 * ch), {2'b00, v});
      apb(1'b0, OFS_PD_BASE + 12'(4 * ch), {2'b00, v});
      apb(1'b1, OFS_PD_STROBE, 32'(1 << ch));
      apb(1'b1, OFS_PD_BASE + 12'(4 * ch), {2'b00, ~v});
      idle(3);
      chk("peer_delay", v, peer_delay[ch]);
      c = {rnd, ~rnd};
      @(posedge pclk);
      ts_update_valid[ch] <= 1'b1;
      ts_corr_in[ch] <= c;
      @(posedge pclk);
      ts_update_valid[ch] <= 1'b0;
      @(negedge pclk);
      chk("ts_corr_out", c + 64'(v), ts_corr_out[ch]);
      chk("ts_corr_valid", 1, ts_corr_valid[ch]);
    end
    ticks = 0;
    repeat (10 * TICK) begin
      @(negedge pclk);
      if (ms_tick === 4'hf) ticks++;
    end
    chk("ms_tick", 10, ticks);
    blocked_frame(1, 1'b0, 32'h0000_0020);
    blocked_frame(2, 1'b0, 32'h0000_0400);
    blocked_frame(3, 1'b1, 32'h0000_0008);
    tx_q.push_back(8'h80);
    pend(3, 1'b1, 1'b1);
    wait_busy(3, 1'b1);
    pend(3, 1'b1, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0808);
    idle(3);
    chk("tx_busy_stop", 1, tx_busy[3]);
    chk("pmac_preempt", 1, pmac_preempt[3]);
    apb(1'b1, OFS_CTRL, CTRL_RESET);
    end_frame(3);
    @(posedge pclk);
    pfc_mode <= 1'b0;
    xoff_rx(PATH_EXPRESS, 0, 16'h0028);
    apb(1'b0, OFS_STAT_E, 32'h0000_0001);
    tx_q.push_back(8'h01);
    pend(0, 1'b0, 1'b1);
    wait_busy(0, 1'b1);
    chk("pause_on", 0, i_qmfc_if.emac_pause_on[0]);
    pend(0, 1'b0, 1'b0);
    end_frame(0);
    @(posedge pclk);
    comp <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_1000);
    xoff_rx(PATH_PREEMPT, 1, 16'h001e);
    apb(1'b0, OFS_STAT_P, 32'h0000_0100);
    idle(4);
    chk("mac_stop_tx", 1, i_qmfc_if.mac_stop_tx[1]);
    idle(40);
    chk("mac_stop_tx", 0, i_qmfc_if.mac_stop_tx[1]);
    end_sim();
  end
endmodule
